// [hdl/ubd_map.vh]
`ifndef UBD_MAP_VH
`define UBD_MAP_VH

// Register byte addresses (Wishbone, one word each)
`define UBD_DESC_LIMIT   12'h200
`define UBD_EVT_FLAGS    12'h200
`define UBD_EVT_ENABLES  12'h204
`define UBD_ERR_FLAGS    12'h208
`define UBD_ERR_ENABLES  12'h20c
`define UBD_CONFIG       12'h210
`define UBD_DEV_ADDR     12'h214
`define UBD_XFER_STATUS  12'h218

// Descriptor field select, address bits 3:2
`define UBD_FLD_STAT     2'h0
`define UBD_FLD_CNT      2'h1
`define UBD_FLD_ADRLO    2'h2
`define UBD_FLD_ADRHI    2'h3

// Descriptor status bits
`define UBD_ST_OWN       7
`define UBD_ST_DTS       6
`define UBD_ST_TOGGLE_CHECK_ENABLE     3
`define UBD_ST_BUFFER_STALL_ENABLE    2

// Event flag bits
`define UBD_EV_SOF       6
`define UBD_EV_STALL     5
`define UBD_EV_IDLE      4
`define UBD_EV_TRN       3
`define UBD_EV_ACTV      2
`define UBD_EV_ERR       1
`define UBD_EV_RST       0
`define UBD_EVT_WMASK    8'h7d
`define UBD_ERR_MASK     8'h9f

// Config bits and reset values
`define UBD_CFG_EN       2
`define UBD_CFG_PPRST    3
`define UBD_RST_BYTE     8'h00
`define UBD_RST_ADDR     7'h00

// Ping-pong modes
`define UBD_PP_NONE      2'h0
`define UBD_PP_EP0OUT    2'h1
`define UBD_PP_ALL       2'h2
`define UBD_PP_ALLBUT0   2'h3

// Idle time, 3 ms of the 40 MHz clock
`define UBD_IDLE_CYCLES  17'd120000

`define UBD_XF_DEPTH     3'h4

`endif

// [hdl/ubd_bd_index.v]
`include "ubd_map.vh"
`default_nettype none

module ubd_bd_index (
	// Selection
	input  wire [1:0] mode,
	input  wire [2:0] ep,
	input  wire       dirIn,
	input  wire       odd,
	// Result
	output wire [4:0] bdIndex
);

	function [5:0] mapIdx;
		input [1:0] m;
		input [2:0] e;
		input       d;
		input       o;
		reg   [5:0] e6;
		begin
			e6 = {3'b000, e};
			mapIdx = 6'h00;
			case (m)
			`UBD_PP_NONE: begin
				mapIdx = {e6[4:0], d};
			end
			`UBD_PP_EP0OUT: begin
				if (e == 3'h0)
					mapIdx = d ? 6'h02 : {5'h00, o};
				else
					mapIdx = {e6[4:0], 1'b0} + 6'h01 + {5'h00, d};
			end
			`UBD_PP_ALL: begin
				mapIdx = {e6[3:0], d, o};
			end
			default: begin
				if (e == 3'h0)
					mapIdx = {5'h00, d};
				else
					mapIdx = {e6[3:0], d, o} - 6'h02;
			end
			endcase
		end
	endfunction

	wire [5:0] idxFull = mapIdx(mode, ep, dirIn, odd);
	assign bdIndex = idxFull[4:0];

endmodule // ubd_bd_index

`default_nettype wire

// [hdl/ubd_core.v]
`include "ubd_map.vh"
`default_nettype none

// Functional notes
// - No ping-pong: endpoint n uses descriptor 2n for OUT, 2n+1 for IN.
// - EP0 OUT ping-pong: EP0 OUT 0/1, IN 2; others 2n+1 and 2n+2.
// - All ping-pong: OUT 4n/4n+1, IN 4n+2/4n+3, up to 31.
// - All but EP0: EP0 uses 0 and 1; others 4n-2/4n-1, 4n/4n+1.
// - 32 descriptors of status, count, two address bytes; no reset value.
// - On completion the engine writes the token identifier into status 5:2.
// - CPU-owned status bits 3 and 2 are toggle check and stall enables.
// - Toggle-sync bit is ignored unless toggle check enable is set.
// - Byte count is ten bits: count byte plus status bits 1:0.
// - Even/odd pointer per endpoint and direction, reset on enable, toggles per completion.
// - All USB sources combine into one interrupt request line.
// - Enabled error flags set the error summary flag.
// - Event flags AND their enables are ORed into the request.
// - Event enables gate only the request; flags still set for polling.
// - Engine-set flags stay until software writes 0 to them.
// - Software may also set writable event flags directly.
// - Flags sit at bits 6..0 as listed; bit 7 reads zero.
// - Frame-start flag sets on a received start-of-frame token.
// - Stall-sent flag sets when a STALL handshake is sent.
// - Idle flag sets after 3 ms of continuous bus idle.
// - Transaction flag sets on completion; clearing it advances status FIFO.
// - Activity flag sets on the first D+/D- activity after idle was detected.
// - Error summary flag is read-only to software.
// - Bus reset sets its flag and clears the device address.
module ubd_core #(
	parameter [16:0] IDLE_CYCLES = `UBD_IDLE_CYCLES
) (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        rst_n,
	// Wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [11:0] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// Engine descriptor lookup
	input  wire [2:0]  engEp,
	input  wire        engDir,
	output reg  [4:0]  engBdIndex,
	output reg         engOwn,
	output reg         engToggle,
	output reg         engToggleChk,
	output reg         engStall,
	output reg  [9:0]  engCount,
	output reg  [15:0] engAddr,
	// Engine completion
	input  wire        engDone,
	input  wire [3:0]  engPid,
	input  wire [9:0]  engDoneCount,
	input  wire        engTokenOk,
	output wire        engReady,
	// Bus events
	input  wire        sofEvt,
	input  wire        stallEvt,
	input  wire        busIdle,
	input  wire        busActivity,
	input  wire        busResetEvt,
	input  wire [7:0]  errEvt,
	// Outputs
	output reg         usbIrq,
	output reg  [6:0]  devAddr,
	output reg  [1:0]  ppMode,
	output reg         modEnable
);

	reg  [1:0]  rstSync;
	wire        rstN = rstSync[1];

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rstSync <= 2'b00;
		else
			rstSync <= {rstSync[0], 1'b1};
	end

	// Descriptor storage, deliberately unreset
	reg  [7:0]  statMem  [0:31];
	reg  [7:0]  cntMem   [0:31];
	reg  [7:0]  adrLoMem [0:31];
	reg  [7:0]  adrHiMem [0:31];

	reg  [7:0]  evtFlags_r;
	reg  [7:0]  evtEn_r;
	reg  [7:0]  errFlags_r;
	reg  [7:0]  errEn_r;
	reg  [15:0] ppPtr_r;
	reg  [16:0] idleCnt_r;
	reg         actArm_r;
	reg  [4:0]  xfMem [0:3];
	reg  [1:0]  xfWr_r;
	reg  [1:0]  xfRd_r;
	reg  [2:0]  xfCnt_r;
	reg  [31:0] rdData;

	// Bus decode
	wire        req    = cyc_i & stb_i & ~ack_o;
	wire        wrReq  = req & we_i & sel_i[0];
	wire        isDesc = adr_i < `UBD_DESC_LIMIT;
	wire [4:0]  busIdx = adr_i[8:4];
	wire        wrDesc = wrReq & isDesc;
	wire        wrEvt  = wrReq & (adr_i == `UBD_EVT_FLAGS);
	wire        wrErr  = wrReq & (adr_i == `UBD_ERR_FLAGS);
	wire        wrCfg  = wrReq & (adr_i == `UBD_CONFIG);

	// Engine side index
	wire [3:0]  ptrSel = {engEp, engDir};
	wire        ptrOdd = ppPtr_r[ptrSel];
	wire [4:0]  bdIdx;

	ubd_bd_index uIndex (
		.mode    (ppMode),
		.ep      (engEp),
		.dirIn   (engDir),
		.odd     (ptrOdd),
		.bdIndex (bdIdx)
	);

	// Status FIFO control
	wire        xfFull  = xfCnt_r == `UBD_XF_DEPTH;
	wire        xfEmpty = xfCnt_r == 3'h0;
	wire        xfPush  = engDone & engTokenOk & ~xfFull;
	// Clearing the flag is the only pop, so software paces the FIFO
	wire        xfPop   = wrEvt & evtFlags_r[`UBD_EV_TRN] &
	                      ~dat_i[`UBD_EV_TRN] & ~xfEmpty;
	// Engine must hold a completion while the FIFO is full
	assign engReady = ~xfFull;

	// Event sources
	wire        idleHit = busIdle & (idleCnt_r == IDLE_CYCLES - 17'h1);
	wire        actvSet = busActivity & actArm_r;
	wire        errSum  = |(errFlags_r & errEn_r);
	wire        trnSet  = xfPush | (xfPop & (xfCnt_r > 3'h1));
	wire [7:0]  hwSet   = {1'b0,
	                       sofEvt,
	                       stallEvt,
	                       idleHit,
	                       trnSet,
	                       actvSet,
	                       1'b0,
	                       busResetEvt};
	wire [7:0]  evtView = {1'b0, evtFlags_r[6:2], errSum,
	                       evtFlags_r[0]};

	reg  [7:0]  evtFlags_nxt;
	reg  [7:0]  errFlags_nxt;

	always @* begin
		evtFlags_nxt = evtFlags_r;
		if (wrEvt)
			evtFlags_nxt = (dat_i[7:0] & `UBD_EVT_WMASK) |
			               (evtFlags_r & ~`UBD_EVT_WMASK);
		// A set in the clearing cycle is never lost
		evtFlags_nxt = (evtFlags_nxt | hwSet) & `UBD_EVT_WMASK;
		errFlags_nxt = errFlags_r;
		if (wrErr)
			errFlags_nxt = errFlags_r & dat_i[7:0];
		errFlags_nxt = (errFlags_nxt | errEvt) & `UBD_ERR_MASK;
	end

	// Flags, enables, config
	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			evtFlags_r <= `UBD_RST_BYTE;
			evtEn_r    <= `UBD_RST_BYTE;
			errFlags_r <= `UBD_RST_BYTE;
			errEn_r    <= `UBD_RST_BYTE;
			devAddr    <= `UBD_RST_ADDR;
			ppMode     <= `UBD_PP_NONE;
			modEnable  <= 1'b0;
			usbIrq     <= 1'b0;
		end else begin
			evtFlags_r <= evtFlags_nxt;
			errFlags_r <= errFlags_nxt;
			if (wrReq & (adr_i == `UBD_EVT_ENABLES))
				evtEn_r <= dat_i[7:0] & `UBD_EVT_WMASK | 8'h02 & dat_i[7:0];
			if (wrReq & (adr_i == `UBD_ERR_ENABLES))
				errEn_r <= dat_i[7:0] & `UBD_ERR_MASK;
			if (busResetEvt)
				devAddr <= `UBD_RST_ADDR;
			else if (wrReq & (adr_i == `UBD_DEV_ADDR))
				devAddr <= dat_i[6:0];
			if (wrCfg) begin
				ppMode    <= dat_i[1:0];
				modEnable <= dat_i[`UBD_CFG_EN];
			end
			usbIrq <= |(evtView & evtEn_r);
		end
	end

	// Idle timer and one-shot activity arming
	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			idleCnt_r <= 17'h0;
			actArm_r  <= 1'b0;
		end else begin
			if (!busIdle)
				idleCnt_r <= 17'h0;
			else if (idleCnt_r != IDLE_CYCLES)
				idleCnt_r <= idleCnt_r + 17'h1;
			// Only one activity event per resume from idle
			if (idleHit)
				actArm_r <= 1'b1;
			else if (actvSet)
				actArm_r <= 1'b0;
		end
	end

	// Ping-pong pointers
	wire        enRise = wrCfg & dat_i[`UBD_CFG_EN] & ~modEnable;
	wire        ptrClr = enRise | (wrCfg & dat_i[`UBD_CFG_PPRST]);

	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN)
			ppPtr_r <= 16'h0000;
		else if (ptrClr)
			ppPtr_r <= 16'h0000;
		else if (engDone)
			ppPtr_r[ptrSel] <= ~ptrOdd;
	end

	// Transfer status FIFO
	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			xfWr_r  <= 2'h0;
			xfRd_r  <= 2'h0;
			xfCnt_r <= 3'h0;
		end else begin
			if (xfPush)
				xfWr_r <= xfWr_r + 2'h1;
			if (xfPop)
				xfRd_r <= xfRd_r + 2'h1;
			if (xfPush & ~xfPop)
				xfCnt_r <= xfCnt_r + 3'h1;
			else if (xfPop & ~xfPush)
				xfCnt_r <= xfCnt_r - 3'h1;
		end
	end

	always @(posedge ref_clk) begin
		if (xfPush)
			xfMem[xfWr_r] <= {engEp, engDir, ptrOdd};
	end

	// Descriptor writes; engine completion wins over a bus write
	always @(posedge ref_clk) begin
		if (wrDesc) begin
			if (adr_i[3:2] == `UBD_FLD_STAT)
				statMem[busIdx] <= dat_i[7:0];
			else if (adr_i[3:2] == `UBD_FLD_CNT)
				cntMem[busIdx] <= dat_i[7:0];
			else if (adr_i[3:2] == `UBD_FLD_ADRLO)
				adrLoMem[busIdx] <= dat_i[7:0];
			else
				adrHiMem[busIdx] <= dat_i[7:0];
		end
		if (engDone) begin
			// Ownership returns to the CPU; bit 6 left as it was
			statMem[bdIdx] <= {1'b0, statMem[bdIdx][`UBD_ST_DTS], engPid,
			                   engDoneCount[9:8]};
			cntMem[bdIdx]  <= engDoneCount[7:0];
		end
	end

	// Engine view of the selected descriptor
	wire [7:0]  engStat = statMem[bdIdx];

	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			engBdIndex   <= 5'h00;
			engOwn       <= 1'b0;
			engToggle    <= 1'b0;
			engToggleChk <= 1'b0;
			engStall     <= 1'b0;
			engCount     <= 10'h000;
			engAddr      <= 16'h0000;
		end else begin
			engBdIndex   <= bdIdx;
			engOwn       <= engStat[`UBD_ST_OWN];
			// Setup bits only mean something as handed over by the CPU
			engToggleChk <= engStat[`UBD_ST_TOGGLE_CHECK_ENABLE];
			engStall     <= engStat[`UBD_ST_BUFFER_STALL_ENABLE];
			engToggle    <= engStat[`UBD_ST_DTS] &
			                engStat[`UBD_ST_TOGGLE_CHECK_ENABLE];
			engCount     <= {engStat[1:0], cntMem[bdIdx]};
			engAddr      <= {adrHiMem[bdIdx], adrLoMem[bdIdx]};
		end
	end

	// Read mux; unmapped reads as zero
	always @* begin
		rdData = 32'h0000_0000;
		if (isDesc) begin
			if (adr_i[3:2] == `UBD_FLD_STAT)
				rdData[7:0] = statMem[busIdx];
			else if (adr_i[3:2] == `UBD_FLD_CNT)
				rdData[7:0] = cntMem[busIdx];
			else if (adr_i[3:2] == `UBD_FLD_ADRLO)
				rdData[7:0] = adrLoMem[busIdx];
			else
				rdData[7:0] = adrHiMem[busIdx];
		end else if (adr_i == `UBD_EVT_FLAGS)
			rdData[7:0] = evtView;
		else if (adr_i == `UBD_EVT_ENABLES)
			rdData[7:0] = evtEn_r;
		else if (adr_i == `UBD_ERR_FLAGS)
			rdData[7:0] = errFlags_r;
		else if (adr_i == `UBD_ERR_ENABLES)
			rdData[7:0] = errEn_r;
		else if (adr_i == `UBD_CONFIG)
			rdData[7:0] = {5'h00, modEnable, ppMode};
		else if (adr_i == `UBD_DEV_ADDR)
			rdData[7:0] = {1'b0, devAddr};
		else if (adr_i == `UBD_XFER_STATUS)
			rdData[7:0] = {2'b00, xfMem[xfRd_r], ~xfEmpty};
	end

	// Single wait state answer to every address
	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			if (req)
				dat_o <= rdData;
		end
	end

endmodule // ubd_core

`default_nettype wire

// [test/ubd_core_monitor.sv]
`default_nettype none
module ubd_core_monitor (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Bus handshake
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       ack_o,
	// Lookup and control
	input wire logic [2:0] engEp,
	input wire logic       engDir,
	input wire logic [4:0] engBdIndex,
	input wire logic [1:0] ppMode,
	input wire logic       busResetEvt,
	input wire logic [6:0] devAddr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered");
	ack_single_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	addr_clear_a: assert property (busResetEvt |=> devAddr == 7'h00)
		else $error("address kept after bus reset");
	// Mode is taken from the cycle of the lookup, not the answer
	map_none_a: assert property ($past(ppMode) == 2'h0 |->
		engBdIndex == {$past(engEp), $past(engDir)})
		else $error("index wrong, mode 0");
	map_ep0out_a: assert property ($past(ppMode) == 2'h1 &&
		$past(engEp) != 3'h0 |->
		engBdIndex == {1'b0, $past(engEp), 1'b0} + 5'h01 + $past(engDir))
		else $error("index wrong, mode 1");
	map_all_a: assert property ($past(ppMode) == 2'h2 |->
		engBdIndex[4:1] == {$past(engEp), $past(engDir)})
		else $error("index wrong, mode 2");
	map_rest_a: assert property ($past(ppMode) == 2'h3 &&
		$past(engEp) != 3'h0 |->
		engBdIndex[4:1] == {$past(engEp), $past(engDir)} - 4'h1)
		else $error("index wrong, mode 3");
	map_ep0_a: assert property ($past(ppMode) == 2'h3 &&
		$past(engEp) == 3'h0 |-> engBdIndex == {4'h0, $past(engDir)})
		else $error("index wrong, mode 3 ep0");
endmodule // ubd_core_monitor
`default_nettype wire

// [test/ubd_eng_model.sv]
`default_nettype none
module ubd_eng_model (
	// Clock and flow control
	input  wire logic       ref_clk,
	input  wire logic       engReady,
	// Completion
	output var  logic       engDone,
	output var  logic [3:0] engPid,
	output var  logic [9:0] engDoneCount,
	output var  logic       engTokenOk,
	// Bus events
	output var  logic       sofEvt,
	output var  logic       stallEvt,
	output var  logic       busIdle,
	output var  logic       busActivity,
	output var  logic       busResetEvt,
	output var  logic [7:0] errEvt
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{engDone, engPid, engDoneCount, engTokenOk} = '0;
		{sofEvt, stallEvt, busIdle, busActivity, busResetEvt} = '0;
		errEvt = 8'h00;
	end
	// Pulse {err, sof, stall, activity, reset} for one cycle
	task automatic pulse(input logic [11:0] v);
		{errEvt, sofEvt, stallEvt, busActivity, busResetEvt} <= v;
		@(posedge ref_clk);
		{errEvt, sofEvt, stallEvt, busActivity, busResetEvt} <= 12'h000;
	endtask
	// Token identifier and count of a finished transfer
	task automatic done(input logic [3:0] p, input logic [9:0] n);
		while (engReady !== 1'b1) @(posedge ref_clk);
		{engDone, engTokenOk, engPid, engDoneCount} <= {2'b11, p, n};
		@(posedge ref_clk);
		// Stale values would hide a late sample
		{engDone, engTokenOk, engPid, engDoneCount} <= {2'b00, ~p, ~n};
	endtask
	task automatic idle(input int n);
		busIdle <= 1'b1;
		repeat (n) @(posedge ref_clk);
		busIdle <= 1'b0;
	endtask
endmodule // ubd_eng_model
`default_nettype wire

// [test/ubd_core_tb.sv]
`default_nettype none
module ubd_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, rst_n, cyc_i, stb_i, we_i, ack_o, engDir, engOwn;
	logic        engReady, usbIrq, engDone, engTokenOk, sofEvt, stallEvt;
	logic        busIdle, busActivity, busResetEvt;
	logic        engToggle, engToggleChk, engStall, modEnable;
	logic [15:0] engAddr;
	logic [31:0] dat_i, dat_o;
	logic [11:0] adr_i;
	logic [9:0]  engCount, engDoneCount;
	logic [7:0]  errEvt, q;
	logic [6:0]  devAddr;
	logic [4:0]  engBdIndex;
	logic [3:0]  engPid, sel_i;
	logic [2:0]  engEp;
	logic [1:0]  ppMode;
	int          errTotal, nCompared;

	ubd_core #(.IDLE_CYCLES(17'd20)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .engEp(engEp), .engDir(engDir),
		.engBdIndex(engBdIndex), .engOwn(engOwn), .engToggle(engToggle),
		.engToggleChk(engToggleChk), .engStall(engStall),
		.engCount(engCount), .engAddr(engAddr),
		.engDone(engDone), .engPid(engPid), .engDoneCount(engDoneCount),
		.engTokenOk(engTokenOk), .engReady(engReady), .sofEvt(sofEvt),
		.stallEvt(stallEvt), .busIdle(busIdle), .busActivity(busActivity),
		.busResetEvt(busResetEvt), .errEvt(errEvt), .usbIrq(usbIrq),
		.devAddr(devAddr), .ppMode(ppMode), .modEnable(modEnable));
	ubd_eng_model m (.ref_clk(ref_clk), .engReady(engReady),
		.engDone(engDone), .engPid(engPid), .engDoneCount(engDoneCount),
		.engTokenOk(engTokenOk), .sofEvt(sofEvt), .stallEvt(stallEvt),
		.busIdle(busIdle), .busActivity(busActivity),
		.busResetEvt(busResetEvt), .errEvt(errEvt));

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		nCompared++;
		if (s !== e) begin
			errTotal++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// Request is held until ack is seen, then idles one cycle
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] r);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
		do
			@(posedge ref_clk);
		while (ack_o !== 1'b1);
		r = dat_o[7:0];
		{cyc_i, stb_i} <= 2'b00;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		wb(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	function automatic logic [4:0] bdx(input int md, e, d);
		case (md)
			0: return 5'(2 * e + d);
			1: return (e == 0) ? 5'(2 * d) : 5'(2 * e + 1 + d);
			2: return 5'(4 * e + 2 * d);
			default: return (e == 0) ? 5'(d) : 5'(4 * e - 2 + 2 * d);
		endcase
	endfunction
	task automatic endOfTest;
		$display("compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		errTotal++;
		endOfTest;
	end
	initial begin
		{rst_n, cyc_i, stb_i, we_i, adr_i, dat_i, engEp, engDir} = '0;
		sel_i = 4'h1;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rc(12'h200, 8'h00);
		wr(12'h200, 8'hff);
		rc(12'h200, 8'h7d);
		rc(12'h21c, 8'h00);
		wr(12'h200, 8'h00);
		rc(12'h200, 8'h00);
		wr(12'h214, 8'h55);
		// Write without byte lane 0 must not land
		sel_i <= 4'h0;
		wr(12'h214, 8'h33);
		sel_i <= 4'h1;
		rc(12'h214, 8'h55);
		m.pulse(12'h00d);
		rc(12'h200, 8'h61);
		chk(devAddr, 10'h000);
		chk(usbIrq, 10'h000);
		wr(12'h204, 8'hff);
		rc(12'h204, 8'h7f);
		chk(usbIrq, 10'h001);
		wr(12'h200, 8'h00);
		chk(usbIrq, 10'h000);
		wr(12'h204, 8'h00);
		wr(12'h20c, 8'h01);
		m.pulse(12'h810);
		rc(12'h208, 8'h81);
		rc(12'h200, 8'h02);
		wr(12'h200, 8'h00);
		rc(12'h200, 8'h02);
		wr(12'h20c, 8'h00);
		rc(12'h200, 8'h00);
		wr(12'h208, 8'h00);
		rc(12'h208, 8'h00);
		m.idle(19);
		rc(12'h200, 8'h00);
		m.idle(20);
		rc(12'h200, 8'h10);
		wr(12'h204, 8'h04);
		chk(usbIrq, 16'h0000);
		m.pulse(12'h002);
		rc(12'h200, 8'h14);
		chk(usbIrq, 16'h0001);
		wr(12'h200, 8'h00);
		wr(12'h204, 8'h00);
		for (int md = 0; md < 4; md++) begin
			wr(12'h210, 8'(12 + md));
			chk(ppMode, 16'(md));
			for (int k = 0; k < 16; k++) begin
				engEp <= 3'(k / 2);
				engDir <= k[0];
				repeat (2) @(posedge ref_clk);
				chk(engBdIndex, bdx(md, k / 2, k % 2));
			end
		end
		wr(12'h210, 8'h0e);
		chk(modEnable, 16'h0001);
		engEp <= 3'h1;
		engDir <= 1'b0;
		wr(12'h040, 8'hc0);
		wr(12'h044, 8'h10);
		wr(12'h048, 8'h34);
		wr(12'h04c, 8'h12);
		chk(engToggle, 16'h0000);
		chk(engAddr, 16'h1234);
		wr(12'h040, 8'hcc);
		chk(engCount, 16'h0010);
		chk(engOwn, 16'h0001);
		chk(engToggle, 16'h0001);
		chk(engToggleChk, 16'h0001);
		chk(engStall, 16'h0001);
		m.done(4'h9, 10'h305);
		repeat (2) @(posedge ref_clk);
		chk(engBdIndex, 10'h005);
		rc(12'h040, 8'h67);
		rc(12'h044, 8'h05);
		rc(12'h200, 8'h08);
		rc(12'h218, 8'h09);
		wr(12'h200, 8'h00);
		wb(1'b0, 12'h218, 8'h00, q);
		chk(q[0], 10'h000);
		// Fill the status FIFO; the engine is then held off
		repeat (4) begin
			m.done(4'h2, 10'h001);
			@(posedge ref_clk);
		end
		chk(engReady, 16'h0000);
		wr(12'h200, 8'h00);
		rc(12'h200, 8'h08);
		chk(engReady, 16'h0001);
		endOfTest;
	end
endmodule // ubd_core_tb

bind ubd_core ubd_core_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .engEp(engEp),
	.engDir(engDir), .engBdIndex(engBdIndex), .ppMode(ppMode),
	.busResetEvt(busResetEvt), .devAddr(devAddr));
`default_nettype wire
